// file: rtl/xmove_phase_counter.sv
// machine-cycle phase counter, four clocks per machine cycle
`timescale 1ns/10ps
module xmove_phase_counter (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // phase
    input wire logic run,
    output logic [1:0] phase
);
    import xmove_wait_pkg::*;
    logic [1:0] next_phase;

    always_comb begin
        next_phase = run ? 2'(phase + 2'h1) : PHASE_ONE;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            phase <= PHASE_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    // every clock of a running move must advance the phase, so a cycle is four clocks
    property p_wrap;
        @(posedge CLK) disable iff (SYS_RST)
        run |=> phase == 2'($past(phase) + 2'h1);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("phase did not advance by one while running");
endmodule

// file: rtl/xmove_wait_ctrl.sv
// external data move timing with stretch and hardware wait extension
`timescale 1ns/10ps
module xmove_wait_ctrl (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // move request from the core, taken in idle
    input wire xmove_wait_pkg::move_req_t MOVE_REQ,
    output xmove_wait_pkg::move_stat_t MOVE_STAT,
    // special-function register writes
    input wire logic MAP_WR,
    input wire logic MAP_WR_UNLOCKED,
    input wire logic CLK_CTRL_WR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] MEMORY_MAP_CONTROL,
    output logic [7:0] CLOCK_CONTROL_REGISTER,
    // port four bit zero: plain port data or extend request
    input wire logic PORT_FOUR_BIT_ZERO,
    output logic PORT_FOUR_BIT_ZERO_AS_WAIT,
    output logic EXTEND_REQ_SEEN
);
    import xmove_wait_pkg::*;

    move_state_t state, next_state;
    logic [7:0] next_map, next_clk_ctrl;
    logic [3:0] cycles_left, next_cycles_left;
    logic write_mode, next_write_mode;
    logic strobe, next_strobe;
    logic done, next_done;
    logic seen, next_seen;
    logic [1:0] phase;
    logic extend_enable;
    logic [2:0] stretch_select;
    logic extend_active;

    xmove_phase_counter u_phase (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .run(state != S_IDLE),
        .phase(phase)
    );

    function automatic logic [3:0] move_cycles(input logic [2:0] sel);
        return 4'(MOVE_BASE_CYCLES + {1'b0, sel});
    endfunction

    assign extend_enable = MEMORY_MAP_CONTROL[EXTEND_ENABLE_BIT];
    assign stretch_select = CLOCK_CONTROL_REGISTER[STRETCH_MSB:STRETCH_LSB];
    // the pin becomes the wait input only while extension is enabled
    assign PORT_FOUR_BIT_ZERO_AS_WAIT = extend_enable;
    assign extend_active = extend_enable && PORT_FOUR_BIT_ZERO;

    // register writes
    always_comb begin
        next_map = MEMORY_MAP_CONTROL;
        next_clk_ctrl = CLOCK_CONTROL_REGISTER;
        // unlock qualifies the whole register; a plain write is dropped
        if (MAP_WR && MAP_WR_UNLOCKED) begin
            next_map = SFR_WDATA;
        end
        if (CLK_CTRL_WR) begin
            next_clk_ctrl = SFR_WDATA;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MEMORY_MAP_CONTROL <= MEMORY_MAP_RESET;
            CLOCK_CONTROL_REGISTER <= CLOCK_CONTROL_RESET;
        end else begin
            MEMORY_MAP_CONTROL <= next_map;
            CLOCK_CONTROL_REGISTER <= next_clk_ctrl;
        end
    end

    // move sequencer: one fetch cycle, then access cycles counted down
    always_comb begin
        next_state = state;
        next_cycles_left = cycles_left;
        next_write_mode = write_mode;
        next_strobe = strobe;
        next_done = 1'b0;
        next_seen = seen;
        case (state)
            S_IDLE: begin
                next_seen = 1'b0;
                if (MOVE_REQ.start) begin
                    next_state = S_FETCH;
                    next_write_mode = MOVE_REQ.write;
                    // stretch is latched so a mid-move write cannot cut it short
                    next_cycles_left = 4'(move_cycles(stretch_select) - 4'h1);
                end
            end
            S_FETCH: begin
                if (phase == PHASE_FOUR) begin
                    next_state = S_ACCESS;
                    // latched count of one means stretch 0: strobe only in phases 2..3
                    // uses the latched count so a write during fetch cannot change it
                    next_strobe = (cycles_left != 4'h1);
                end
            end
            S_ACCESS: begin
                if (phase == PHASE_ONE && cycles_left == 4'h1) begin
                    next_strobe = 1'b1;
                end
                if (phase == PHASE_THREE && cycles_left == 4'h1) begin
                    if (extend_active) begin
                        // wait cycle keeps strobe asserted
                        next_seen = 1'b1;
                        next_state = S_WAIT;
                    end else begin
                        next_strobe = 1'b0;
                    end
                end
                if (phase == PHASE_FOUR) begin
                    if (cycles_left == 4'h1 && state == next_state) begin
                        next_state = S_IDLE;
                        next_done = 1'b1;
                    end else if (state == next_state) begin
                        next_cycles_left = 4'(cycles_left - 4'h1);
                    end
                end
            end
            S_WAIT: begin
                // no count limit on waits
                if (phase == PHASE_THREE) begin
                    if (!extend_active) begin
                        next_strobe = 1'b0;
                        next_state = S_ACCESS;
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= S_IDLE;
            cycles_left <= 4'h0;
            write_mode <= 1'b0;
            strobe <= 1'b0;
            done <= 1'b0;
            seen <= 1'b0;
        end else begin
            state <= next_state;
            cycles_left <= next_cycles_left;
            write_mode <= next_write_mode;
            strobe <= next_strobe;
            done <= next_done;
            seen <= next_seen;
        end
    end

    assign MOVE_STAT.read_strobe = strobe && !write_mode;
    assign MOVE_STAT.write_strobe = strobe && write_mode;
    assign MOVE_STAT.busy = (state != S_IDLE);
    assign MOVE_STAT.done = done;
    assign EXTEND_REQ_SEEN = seen;

    // clock counter for checking move length
    logic [7:0] clocks_in_move;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            clocks_in_move <= 8'h00;
        end else if (state == S_IDLE) begin
            clocks_in_move <= 8'h00;
        end else if (clocks_in_move != 8'hFF) begin
            clocks_in_move <= 8'(clocks_in_move + 8'h01);
        end
    end

    property p_min_length;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(done) |-> clocks_in_move >= 8'(PHASES_PER_CYCLE * move_cycles(stretch_select));
    endproperty
    a_min_length: assert property (p_min_length)
        else $error("move shorter than stretch length");

    property p_wait_enter;
        @(posedge CLK) disable iff (SYS_RST)
        state == S_ACCESS && phase == PHASE_THREE && cycles_left == 4'h1 && extend_active
        |=> state == S_WAIT && strobe;
    endproperty
    a_wait_enter: assert property (p_wait_enter)
        else $error("active sample did not insert wait");

    property p_ignore_disabled;
        @(posedge CLK) disable iff (SYS_RST)
        !extend_enable |-> ##1 state != S_WAIT || $past(state) == S_WAIT;
    endproperty
    a_ignore_disabled: assert property (p_ignore_disabled)
        else $error("wait entered with extension disabled");

    property p_wait_exit;
        @(posedge CLK) disable iff (SYS_RST)
        state == S_WAIT && phase == PHASE_THREE && !extend_active
        |=> !strobe ##1 done;
    endproperty
    a_wait_exit: assert property (p_wait_exit)
        else $error("move did not finish after inactive sample");

    property p_protect;
        @(posedge CLK) disable iff (SYS_RST)
        MAP_WR && !MAP_WR_UNLOCKED |=> $stable(MEMORY_MAP_CONTROL);
    endproperty
    a_protect: assert property (p_protect)
        else $error("unprotected write changed extend enable");

    property p_wait_cycle;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(state == S_WAIT) |-> (state == S_WAIT && strobe)[*4];
    endproperty
    a_wait_cycle: assert property (p_wait_cycle)
        else $error("wait cycle shorter than four clocks");

    property p_pin_alt;
        @(posedge CLK) disable iff (SYS_RST)
        state == S_WAIT |-> PORT_FOUR_BIT_ZERO_AS_WAIT && extend_enable;
    endproperty
    a_pin_alt: assert property (p_pin_alt)
        else $error("wait used without pin alternate function");

    property p_sample_phase;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(seen) |-> $past(phase) == PHASE_THREE;
    endproperty
    a_sample_phase: assert property (p_sample_phase)
        else $error("request sampled outside third phase");

    c_read: cover property (@(posedge CLK) disable iff (SYS_RST)
        $rose(MOVE_STAT.read_strobe));
    c_write: cover property (@(posedge CLK) disable iff (SYS_RST)
        $rose(MOVE_STAT.write_strobe));
    c_wait: cover property (@(posedge CLK) disable iff (SYS_RST)
        state == S_WAIT ##4 state == S_WAIT);
    c_done_waited: cover property (@(posedge CLK) disable iff (SYS_RST) done && seen);
endmodule

// file: rtl/xmove_wait_pkg.sv
// constants and types for the external data move wait-state control
package xmove_wait_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_ONE = 2'h0;
    localparam logic [1:0] PHASE_THREE = 2'h2;
    localparam logic [1:0] PHASE_FOUR = 2'h3;
    localparam int EXTEND_ENABLE_BIT = 7;
    localparam int STRETCH_MSB = 2;
    localparam int STRETCH_LSB = 0;
    localparam logic [7:0] MEMORY_MAP_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
    localparam logic [3:0] MOVE_BASE_CYCLES = 4'h2;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_FETCH = 4'b0010,
        S_ACCESS = 4'b0100,
        S_WAIT = 4'b1000
    } move_state_t;

    typedef struct packed {
        logic start;
        logic write;
    } move_req_t;

    typedef struct packed {
        logic read_strobe;
        logic write_strobe;
        logic busy;
        logic done;
    } move_stat_t;
endpackage

// file: test/external_data_wait_state_control_tb_top.sv
// testbench for the external data move wait-state control
`timescale 1ns/10ps
module external_data_wait_state_control_tb_top;
    import xmove_wait_pkg::*;
    logic clk, sys_rst, map_wr, unlock, ck_wr, pin, as_wait, seen_q;
    move_req_t move_req;
    move_stat_t st;
    logic [7:0] wdata, map_ctrl, ck_ctrl, hold;
    int err_total, n_checks;

    xmove_wait_ctrl xmove_wait_ctrl_inst (.CLK(clk), .SYS_RST(sys_rst), .MOVE_REQ(move_req),
        .MOVE_STAT(st), .MAP_WR(map_wr), .MAP_WR_UNLOCKED(unlock), .CLK_CTRL_WR(ck_wr),
        .SFR_WDATA(wdata), .MEMORY_MAP_CONTROL(map_ctrl), .CLOCK_CONTROL_REGISTER(ck_ctrl),
        .PORT_FOUR_BIT_ZERO(pin), .PORT_FOUR_BIT_ZERO_AS_WAIT(as_wait),
        .EXTEND_REQ_SEEN(seen_q));
    xmove_slow_peripheral xmove_slow_peripheral_inst (.clk(clk), .rst(sys_rst),
        .strobe(st.read_strobe | st.write_strobe), .hold_clocks(hold), .req(pin));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic sfr_write(input logic to_map, input logic unl, input logic [7:0] data);
        @(posedge clk);
        map_wr <= to_map;
        unlock <= unl;
        ck_wr <= !to_map;
        wdata <= data;
        @(posedge clk);
        map_wr <= 1'b0;
        unlock <= 1'b0;
        ck_wr <= 1'b0;
        #1;
    endtask

    // start is held one extra cycle on purpose: that copy must be ignored
    task automatic run_move(input logic wr, input int cyc, input logic seen_exp);
        int n, good, bad, busy_n;
        logic seen;
        n = 0;
        busy_n = 0;
        good = 0;
        bad = 0;
        seen = 1'b0;
        @(posedge clk);
        move_req <= '{start: 1'b1, write: wr};
        @(posedge clk);
        while (n < 200) begin
            @(posedge clk);
            move_req <= '{start: 1'b0, write: 1'b0};
            #1;
            n++;
            if ((wr ? st.write_strobe : st.read_strobe) === 1'b1) good++;
            if ((wr ? st.read_strobe : st.write_strobe) !== 1'b0) bad++;
            if (seen_q === 1'b1) seen = 1'b1;
            if (st.busy === 1'b1) busy_n++;
            if (st.done === 1'b1) break;
        end
        // done shows in the clock right after the last of the move's 4*cyc clocks
        check("move length", 8'(4 * cyc), 8'(n));
        check("busy cycles", 8'(4 * cyc - 1), 8'(busy_n));
        check("strobe seen", 8'h01, 8'(good > 0));
        check("wrong strobe", 8'h00, 8'(bad));
        check("wait seen", {7'h00, seen_exp}, {7'h00, seen});
    endtask

    task automatic test_reset;
        check("clock control", 8'h01, ck_ctrl);
        check("map control", 8'h00, map_ctrl);
        check("pin as wait", 8'h00, {7'h00, as_wait});
        run_move(1'b0, 3, 1'b0);
    endtask

    // request held through every strobe but not enabled, so no waits
    task automatic test_stretch;
        hold = 8'hFF;
        for (int s = 0; s < 8; s++) begin
            sfr_write(1'b0, 1'b0, 8'(s));
            check("stretch field", 8'(s), {5'h00, ck_ctrl[2:0]});
            run_move(s[0], 2 + s, 1'b0);
        end
    endtask

    task automatic test_protect;
        sfr_write(1'b1, 1'b0, 8'h80);
        check("unprotected set", 8'h00, map_ctrl);
        sfr_write(1'b1, 1'b1, 8'h80);
        check("protected set", 8'h80, map_ctrl);
        check("pin as wait", 8'h01, {7'h00, as_wait});
        sfr_write(1'b1, 1'b0, 8'h00);
        check("unprotected clear", 8'h80, map_ctrl);
    endtask

    // hold of 4*(s+w) clocks straddles w third-phase samples; w=0 tests early request
    task automatic test_waits;
        int wl[3] = '{0, 1, 3};
        for (int s = 1; s < 3; s++) begin
            for (int i = 0; i < 3; i++) begin
                sfr_write(1'b0, 1'b0, 8'(s));
                hold = 8'(4 * (s + wl[i]));
                run_move(wl[i][0], 2 + s + wl[i], wl[i] > 0);
            end
        end
    endtask

    initial begin
        err_total = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        move_req = '{start: 1'b0, write: 1'b0};
        map_wr = 1'b0;
        unlock = 1'b0;
        ck_wr = 1'b0;
        wdata = 8'h00;
        hold = 8'h00;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        test_reset();
        test_stretch();
        test_protect();
        test_waits();
        print_verdict();
    end

    // tests need under 1500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("ERROR watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule

// file: test/xmove_slow_peripheral.sv
// slow peripheral holding the extend request for a set span
`timescale 1ns/10ps
module xmove_slow_peripheral (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // strobe from the device, hold span from the bench
    input wire logic strobe,
    input wire logic [7:0] hold_clocks,
    // extend request pin, high while more time is needed
    output logic req
);
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
        end else begin
            cnt <= strobe ? cnt + 8'h01 : 8'h00;
        end
    end
    // span ends at a cycle boundary so the next sample surely sees it low
    assign req = strobe && (cnt < hold_clocks);
endmodule
